// ==== hw/usx_pkg.sv ====
package usx_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0] USX_IDX_INT_CTRL = 8'h0B;
  localparam logic [7:0] USX_IDX_PERIPH_FLAGS_1 = 8'h0C;
  localparam logic [7:0] USX_IDX_RX_STATUS_CTRL = 8'h18;
  localparam logic [7:0] USX_IDX_TX_HOLDING = 8'h19;
  localparam logic [7:0] USX_IDX_RX_DATA = 8'h1A;
  localparam logic [7:0] USX_IDX_PERIPH_ENABLES_1 = 8'h8C;
  localparam logic [7:0] USX_IDX_TX_STATUS_CTRL = 8'h98;
  localparam logic [7:0] USX_IDX_BAUD_DIVISOR = 8'h99;
  localparam int USX_ADDR_W = 12;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int USX_INT_GLOBAL_EN = 7;
  localparam int USX_INT_PERIPH_EN = 6;
  localparam int USX_PF_RX_DONE = 5;
  localparam int USX_PF_TX_EMPTY = 4;
  localparam int USX_RS_PORT_EN = 7;
  localparam int USX_RS_RX9 = 6;
  localparam int USX_RS_SINGLE_RX = 5;
  localparam int USX_RS_CONT_RX = 4;
  localparam int USX_RS_FRAMING = 2;
  localparam int USX_RS_OVERRUN = 1;
  localparam int USX_RS_RX_NINTH = 0;
  localparam int USX_TS_CLK_SRC = 7;
  localparam int USX_TS_TX9 = 6;
  localparam int USX_TS_TX_EN = 5;
  localparam int USX_TS_SYNC = 4;
  localparam int USX_TS_HIGH_SPEED = 2;
  localparam int USX_TS_SHIFTER_EMPTY = 1;
  localparam int USX_TS_TX_NINTH = 0;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] USX_RST_BYTE = 8'h00;
  localparam logic [7:0] USX_RST_TX_STATUS = 8'h02;

  // ****************************************************************
  // rate generation and framing counts
  // ****************************************************************
  localparam logic [1:0] USX_PRESCALE_NORMAL = 2'h3; // divide by 4 when not high speed
  localparam logic [3:0] USX_OVERSAMPLE_LAST = 4'hF; // 16 ticks per bit
  localparam logic [3:0] USX_START_MID = 4'h7; // middle of start bit
  localparam logic [3:0] USX_BITS_8 = 4'h8;
  localparam logic [3:0] USX_BITS_9 = 4'h9;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } usx_word_s;

  typedef enum logic [1:0] {
    USX_RX_IDLE,
    USX_RX_START,
    USX_RX_DATA,
    USX_RX_STOP
  } usx_rx_state_e;

endpackage : usx_pkg

// ==== hw/usx_baud.sv ====
`timescale 1ns/1ps
`default_nettype none

module usx_baud
  import usx_pkg::*;
#(
  parameter int DIV_W = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // control
  input wire logic enable,
  input wire logic high_speed,
  input wire logic [DIV_W-1:0] divisor,
  // sixteen-times-bit-rate tick
  output logic tick
);

  // ****************************************************************
  // prescaler and divisor counter
  // ****************************************************************
  logic [1:0] pre_reg;
  logic [DIV_W-1:0] div_reg;
  logic pre_tick;

  // high speed skips the divide by four
  assign pre_tick = high_speed || (pre_reg == 2'h0);

  // free prescaler
  always_ff @(posedge clk_sys) begin
    if (srst || !enable) begin
      pre_reg <= USX_PRESCALE_NORMAL;
    end else if (pre_reg == 2'h0) begin
      pre_reg <= USX_PRESCALE_NORMAL;
    end else begin
      pre_reg <= pre_reg - 2'h1;
    end
  end

  // count divisor+1 prescaled steps per tick
  always_ff @(posedge clk_sys) begin
    if (srst || !enable) begin
      div_reg <= '0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (pre_tick) begin
        if (div_reg == '0) begin
          div_reg <= divisor;
          tick <= 1'b1;
        end else begin
          div_reg <= div_reg - DIV_W'(1);
        end
      end
    end
  end

endmodule : usx_baud

`default_nettype wire

// ==== hw/usx_top.sv ====
// Summary of operation
// - normal range divides clock by 64 steps
// - high speed gives four times rate
// - ninth receive bit only when enabled
// - reception starts only with continuous enable
// - done character sets flag, may interrupt
// - status shows ninth bit and errors
// - clearing continuous enable clears errors
// - slave takes shift clock from pin
// - slave keeps transferring during sleep
// - clock source bit clear selects slave
// - slave transmit matches master transmit
// - first word moves to shifter immediately
// - empty flag clear while word held
// - reload shifter, then set empty flag
// - empty event wakes device, vectors interrupt
// - ninth transmit bit from ninth field
// - transmit enabled, starts on holding write
`timescale 1ns/1ps
`default_nettype none

module usx_top
  import usx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [USX_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial pins
  input wire logic rx_data_pin_in,
  output logic rx_data_pin_out,
  output logic rx_data_pin_oe,
  input wire logic shift_clock_pin_in,
  // core power state
  input wire logic sleep_mode,
  output logic int_request,
  output logic wake_request
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [7:0] int_ctrl_reg;
  logic [7:0] enables_reg;
  logic [7:0] baud_divisor_reg;
  logic port_en_reg, rx9_reg, single_rx_reg, cont_rx_reg;
  logic clk_src_reg, tx9_reg, tx_en_reg, sync_reg, high_speed_reg, tx_ninth_reg;
  logic framing_reg, overrun_reg, rx_done_reg;
  usx_word_s rx_word_reg;
  logic [7:0] hold_reg;
  logic hold_full_reg;
  logic [8:0] shifter_reg;
  logic [3:0] tx_left_reg;
  logic rx_meta_reg, rx_sync_reg, ck_meta_reg, ck_sync_reg, ck_dly_reg;
  usx_rx_state_e rx_state_reg;
  logic [3:0] rx_tick_reg, rx_bit_reg;
  logic [8:0] rx_shift_reg;
  logic tick;
  logic acc, wr_go, rd_go, rx_done_set, ck_fall, slave_tx, async_rx, tx_empty;
  logic [7:0] rd_mux;
  logic mapped;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic hit(input logic [USX_ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a[USX_ADDR_W-1:2] == {2'b00, idx}) && (a[1:0] == 2'b00);
  endfunction : hit

  function automatic logic [3:0] frame_bits(input logic nine);
    frame_bits = nine ? USX_BITS_9 : USX_BITS_8;
  endfunction : frame_bits

  // ****************************************************************
  // apb slave, one wait state
  // ****************************************************************
  assign acc = psel && penable;
  assign wr_go = acc && pready && pwrite;
  assign rd_go = acc && pready && !pwrite;
  assign mapped = hit(paddr, USX_IDX_INT_CTRL) || hit(paddr, USX_IDX_PERIPH_FLAGS_1)
    || hit(paddr, USX_IDX_RX_STATUS_CTRL) || hit(paddr, USX_IDX_TX_HOLDING)
    || hit(paddr, USX_IDX_RX_DATA) || hit(paddr, USX_IDX_PERIPH_ENABLES_1)
    || hit(paddr, USX_IDX_TX_STATUS_CTRL) || hit(paddr, USX_IDX_BAUD_DIVISOR);

  // transmitter wants data when enabled and holding is free
  assign tx_empty = tx_en_reg && !hold_full_reg;

  // read multiplexer
  always_comb begin
    rd_mux = 8'h00;
    if (hit(paddr, USX_IDX_INT_CTRL)) begin
      rd_mux = int_ctrl_reg;
    end else if (hit(paddr, USX_IDX_PERIPH_FLAGS_1)) begin
      rd_mux[USX_PF_RX_DONE] = rx_done_reg;
      rd_mux[USX_PF_TX_EMPTY] = tx_empty;
    end else if (hit(paddr, USX_IDX_RX_STATUS_CTRL)) begin
      rd_mux[USX_RS_PORT_EN] = port_en_reg;
      rd_mux[USX_RS_RX9] = rx9_reg;
      rd_mux[USX_RS_SINGLE_RX] = single_rx_reg;
      rd_mux[USX_RS_CONT_RX] = cont_rx_reg;
      rd_mux[USX_RS_FRAMING] = framing_reg;
      rd_mux[USX_RS_OVERRUN] = overrun_reg;
      rd_mux[USX_RS_RX_NINTH] = rx_word_reg.ninth;
    end else if (hit(paddr, USX_IDX_RX_DATA)) begin
      rd_mux = rx_word_reg.data;
    end else if (hit(paddr, USX_IDX_PERIPH_ENABLES_1)) begin
      rd_mux = enables_reg;
    end else if (hit(paddr, USX_IDX_TX_STATUS_CTRL)) begin
      rd_mux[USX_TS_CLK_SRC] = clk_src_reg;
      rd_mux[USX_TS_TX9] = tx9_reg;
      rd_mux[USX_TS_TX_EN] = tx_en_reg;
      rd_mux[USX_TS_SYNC] = sync_reg;
      rd_mux[USX_TS_HIGH_SPEED] = high_speed_reg;
      rd_mux[USX_TS_SHIFTER_EMPTY] = (tx_left_reg == 4'h0);
      rd_mux[USX_TS_TX_NINTH] = tx_ninth_reg;
    end else if (hit(paddr, USX_IDX_BAUD_DIVISOR)) begin
      rd_mux = baud_divisor_reg;
    end
  end

  // handshake and read data capture
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= acc && !pready;
      pslverr <= acc && !pready && !mapped;
      if (acc && !pready) begin
        prdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  // ****************************************************************
  // software control registers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      int_ctrl_reg <= USX_RST_BYTE;
      enables_reg <= USX_RST_BYTE;
      baud_divisor_reg <= USX_RST_BYTE;
      {port_en_reg, rx9_reg, single_rx_reg, cont_rx_reg} <= 4'h0;
      {clk_src_reg, tx9_reg, tx_en_reg, sync_reg} <= USX_RST_TX_STATUS[7:4];
      high_speed_reg <= USX_RST_TX_STATUS[USX_TS_HIGH_SPEED];
      tx_ninth_reg <= USX_RST_TX_STATUS[USX_TS_TX_NINTH];
    end else if (wr_go && mapped) begin
      if (hit(paddr, USX_IDX_INT_CTRL)) begin
        int_ctrl_reg[USX_INT_GLOBAL_EN] <= pwdata[USX_INT_GLOBAL_EN];
        int_ctrl_reg[USX_INT_PERIPH_EN] <= pwdata[USX_INT_PERIPH_EN];
      end
      if (hit(paddr, USX_IDX_PERIPH_ENABLES_1)) begin
        enables_reg <= pwdata[7:0];
      end
      if (hit(paddr, USX_IDX_BAUD_DIVISOR)) begin
        baud_divisor_reg <= pwdata[7:0];
      end
      if (hit(paddr, USX_IDX_RX_STATUS_CTRL)) begin
        port_en_reg <= pwdata[USX_RS_PORT_EN];
        rx9_reg <= pwdata[USX_RS_RX9];
        single_rx_reg <= pwdata[USX_RS_SINGLE_RX];
        cont_rx_reg <= pwdata[USX_RS_CONT_RX];
      end
      if (hit(paddr, USX_IDX_TX_STATUS_CTRL)) begin
        clk_src_reg <= pwdata[USX_TS_CLK_SRC];
        tx9_reg <= pwdata[USX_TS_TX9];
        tx_en_reg <= pwdata[USX_TS_TX_EN];
        sync_reg <= pwdata[USX_TS_SYNC];
        high_speed_reg <= pwdata[USX_TS_HIGH_SPEED];
        tx_ninth_reg <= pwdata[USX_TS_TX_NINTH];
      end
    end
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      {rx_meta_reg, rx_sync_reg} <= 2'b11;
      {ck_meta_reg, ck_sync_reg, ck_dly_reg} <= 3'b000; // no false falling edge after reset
    end else begin
      rx_meta_reg <= rx_data_pin_in;
      rx_sync_reg <= rx_meta_reg;
      ck_meta_reg <= shift_clock_pin_in;
      ck_sync_reg <= ck_meta_reg;
      ck_dly_reg <= ck_sync_reg;
    end
  end

  // external clock falling edge advances the shifter
  assign ck_fall = ck_dly_reg && !ck_sync_reg;

  // ****************************************************************
  // baud rate generator
  // ****************************************************************
  usx_baud #(
    .DIV_W(8)
  ) u_baud (
    .clk_sys(clk_sys),
    .srst(srst),
    .enable(port_en_reg),
    .high_speed(high_speed_reg),
    .divisor(baud_divisor_reg),
    .tick(tick)
  );

  // ****************************************************************
  // asynchronous receiver
  // ****************************************************************
  assign async_rx = port_en_reg && !sync_reg && cont_rx_reg;

  // framing state machine, 16 ticks per bit
  always_ff @(posedge clk_sys) begin
    if (srst || !async_rx) begin
      rx_state_reg <= USX_RX_IDLE;
      rx_tick_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
    end else begin
      unique case (rx_state_reg)
        USX_RX_IDLE: begin
          rx_tick_reg <= 4'h0;
          if (!rx_sync_reg && !overrun_reg) begin
            rx_state_reg <= USX_RX_START;
          end
        end
        USX_RX_START: begin
          if (tick) begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == USX_START_MID) begin
              rx_tick_reg <= 4'h0;
              rx_bit_reg <= 4'h0;
              rx_state_reg <= rx_sync_reg ? USX_RX_IDLE : USX_RX_DATA;
            end
          end
        end
        USX_RX_DATA: begin
          if (tick) begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == USX_OVERSAMPLE_LAST) begin
              rx_shift_reg <= {rx_sync_reg, rx_shift_reg[8:1]};
              rx_bit_reg <= rx_bit_reg + 4'h1;
              if (rx_bit_reg == frame_bits(rx9_reg) - 4'h1) begin
                rx_state_reg <= USX_RX_STOP;
              end
            end
          end
        end
        USX_RX_STOP: begin
          if (tick) begin
            rx_tick_reg <= rx_tick_reg + 4'h1;
            if (rx_tick_reg == USX_OVERSAMPLE_LAST) begin
              rx_state_reg <= USX_RX_IDLE;
            end
          end
        end
      endcase
    end
  end

  // character complete at middle of stop bit
  assign rx_done_set = async_rx && tick && (rx_state_reg == USX_RX_STOP)
    && (rx_tick_reg == USX_OVERSAMPLE_LAST);

  // received word, errors and done flag
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_word_reg <= '0;
      rx_done_reg <= 1'b0;
      framing_reg <= 1'b0;
      overrun_reg <= 1'b0;
    end else begin
      if (rd_go && hit(paddr, USX_IDX_RX_DATA)) begin
        rx_done_reg <= 1'b0;
      end
      if (!cont_rx_reg) begin
        framing_reg <= 1'b0;
        overrun_reg <= 1'b0;
      end
      if (rx_done_set) begin
        if (rx_done_reg && !(rd_go && hit(paddr, USX_IDX_RX_DATA))) begin
          overrun_reg <= 1'b1; // unread word kept, new one lost
        end else begin
          rx_done_reg <= 1'b1;
          framing_reg <= !rx_sync_reg;
          rx_word_reg.ninth <= rx9_reg ? rx_shift_reg[8] : 1'b0;
          rx_word_reg.data <= rx9_reg ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
        end
      end
    end
  end

  // ****************************************************************
  // synchronous slave transmitter
  // ****************************************************************
  assign slave_tx = port_en_reg && sync_reg && !clk_src_reg && tx_en_reg;

  // holding register and shifter, shifter advanced by the external edge only
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      hold_reg <= 8'h00;
      hold_full_reg <= 1'b0;
      shifter_reg <= 9'h000;
      tx_left_reg <= 4'h0;
    end else begin
      if (wr_go && hit(paddr, USX_IDX_TX_HOLDING)) begin
        hold_reg <= pwdata[7:0];
        hold_full_reg <= 1'b1;
      end
      if (!slave_tx) begin
        tx_left_reg <= 4'h0;
      end else if (tx_left_reg == 4'h0) begin
        if (hold_full_reg) begin
          shifter_reg <= {tx_ninth_reg, hold_reg};
          tx_left_reg <= frame_bits(tx9_reg);
          hold_full_reg <= wr_go && hit(paddr, USX_IDX_TX_HOLDING);
        end
      end else if (ck_fall) begin
        shifter_reg <= {1'b0, shifter_reg[8:1]};
        tx_left_reg <= tx_left_reg - 4'h1;
      end
    end
  end

  // data pin drives the shifter's low bit while transmitting
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rx_data_pin_out <= 1'b1;
      rx_data_pin_oe <= 1'b0;
    end else begin
      rx_data_pin_out <= shifter_reg[0];
      rx_data_pin_oe <= slave_tx && !cont_rx_reg && !single_rx_reg;
    end
  end

  // ****************************************************************
  // interrupt request and wake
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      int_request <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      wake_request <= sleep_mode && ((rx_done_reg && enables_reg[USX_PF_RX_DONE])
        || (tx_empty && enables_reg[USX_PF_TX_EMPTY]));
      int_request <= int_ctrl_reg[USX_INT_GLOBAL_EN] && int_ctrl_reg[USX_INT_PERIPH_EN]
        && ((rx_done_reg && enables_reg[USX_PF_RX_DONE])
        || (tx_empty && enables_reg[USX_PF_TX_EMPTY]));
    end
  end

endmodule : usx_top

`default_nettype wire

// ==== sim/usx_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none

module usx_assertions
  import usx_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [USX_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins and power
  input wire logic rx_data_pin_out,
  input wire logic rx_data_pin_oe,
  input wire logic sleep_mode,
  input wire logic int_request,
  input wire logic wake_request
);
  // ****************************************************************
  // address decode and sequences
  // ****************************************************************
  logic hit;
  // aligned access to one of the mapped registers
  assign hit = paddr[1:0] == 2'h0 && paddr[USX_ADDR_W-1:10] == 2'h0 && paddr[9:2] inside {USX_IDX_INT_CTRL,
    USX_IDX_PERIPH_FLAGS_1, USX_IDX_RX_STATUS_CTRL, USX_IDX_TX_HOLDING, USX_IDX_RX_DATA,
    USX_IDX_PERIPH_ENABLES_1, USX_IDX_TX_STATUS_CTRL, USX_IDX_BAUD_DIVISOR};

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (srst);

  sequence access_wait_s;
    psel && penable && !pready;
  endsequence
  sequence asleep_int_s;
    sleep_mode ##1 int_request;
  endsequence

  apb_answer_a: assert property (access_wait_s |=> pready)
    else $error("access phase not answered after one wait cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("slave error without ready");
  unmapped_refused_a: assert property (pready && !hit |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  byte_wide_a: assert property (pready && hit |-> !pslverr && prdata[31:8] == 24'h0)
    else $error("mapped access refused or upper bits set");
  reset_idle_a: assert property ($fell(srst) |-> !pready && rx_data_pin_out && !rx_data_pin_oe
    && !int_request && !wake_request)
    else $error("outputs not idle after reset");
  wake_asleep_a: assert property (wake_request |-> $past(sleep_mode))
    else $error("wake request while awake");
  wake_follow_a: assert property (asleep_int_s |-> wake_request)
    else $error("pending interrupt did not wake");
endmodule : usx_assertions

bind usx_top usx_assertions i_usx_assertions (
  .clk_sys(clk_sys),
  .srst(srst),
  .psel(psel),
  .penable(penable),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .rx_data_pin_out(rx_data_pin_out),
  .rx_data_pin_oe(rx_data_pin_oe),
  .sleep_mode(sleep_mode),
  .int_request(int_request),
  .wake_request(wake_request)
);

`default_nettype wire

// ==== sim/usx_partner.sv ====
`timescale 1ns/1ps
`default_nettype none

module usx_partner (
  // clock
  input wire logic clk_sys,
  // level seen on the shared data pin
  input wire logic line_in,
  // driven toward the block
  output var logic rx_line,
  output var logic shift_clk
);
  // ****************************************************************
  // remote transmitter and clocking master
  // ****************************************************************
  // line pulled high, shift clock parked low outside frames
  initial begin
    rx_line = 1'b1;
    shift_clk = 1'b0;
  end

  // start, lsb first data, stop, then one idle bit
  task automatic send_frame(input logic [8:0] d, input int nb, input int bc, input logic stop);
    for (int i = -1; i <= nb; i++) begin
      rx_line <= (i < 0) ? 1'b0 : (i == nb) ? stop : d[i];
      repeat (bc) @(posedge clk_sys);
    end
    rx_line <= 1'b1;
    repeat (bc) @(posedge clk_sys);
  endtask : send_frame

  // 80 ns shift clock: sample on rise, block shifts on fall
  task automatic shift_word(input int nb, output logic [8:0] got);
    got = 9'h000;
    for (int i = 0; i < nb; i++) begin
      shift_clk <= 1'b1;
      got[i] = line_in;
      repeat (5) @(posedge clk_sys);
      shift_clk <= 1'b0;
      repeat (5) @(posedge clk_sys);
    end
  endtask : shift_word
endmodule : usx_partner

`default_nettype wire

// ==== sim/usx_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module usx_top_tb
  import usx_pkg::*;
;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [USX_ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic sleep_mode = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, pin_out, pin_oe, pin_wire, rx_line, shift_clk, int_request, wake_request;
  int err_total = 0;
  int comparisons = 0;

  always #4 clk_sys = ~clk_sys;
  // shared data pin level
  assign pin_wire = pin_oe ? pin_out : rx_line;

  usx_top i_usx_top (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_data_pin_in(pin_wire), .rx_data_pin_out(pin_out), .rx_data_pin_oe(pin_oe),
    .shift_clock_pin_in(shift_clk), .sleep_mode(sleep_mode), .int_request(int_request),
    .wake_request(wake_request));
  usx_partner i_usx_partner (.clk_sys(clk_sys), .line_in(pin_wire), .rx_line(rx_line), .shift_clk(shift_clk));

  // ****************************************************************
  // bus and checking tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic apb(input logic w, input logic [USX_ADDR_W-1:0] a, input logic [7:0] d,
      output logic [7:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb

  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'b1, {2'h0, i, 2'h0}, d, r, e);
  endtask : wreg

  task automatic rchk(input logic [7:0] i, input logic [7:0] x);
    logic [7:0] r;
    logic e;
    apb(1'b0, {2'h0, i, 2'h0}, 8'h00, r, e);
    check({e, r}, {1'b0, x});
  endtask : rchk

  // reset values, storage and refused addresses
  task automatic t_regs();
    logic [7:0] r;
    logic e;
    rchk(USX_IDX_INT_CTRL, 8'h00);
    rchk(USX_IDX_PERIPH_FLAGS_1, 8'h00);
    rchk(USX_IDX_RX_STATUS_CTRL, 8'h00);
    rchk(USX_IDX_RX_DATA, 8'h00);
    rchk(USX_IDX_PERIPH_ENABLES_1, 8'h00);
    rchk(USX_IDX_TX_STATUS_CTRL, 8'h02);
    rchk(USX_IDX_BAUD_DIVISOR, 8'h00);
    wreg(USX_IDX_BAUD_DIVISOR, 8'hFF);
    wreg(USX_IDX_INT_CTRL, 8'hFF);
    rchk(USX_IDX_INT_CTRL, 8'hC0);
    apb(1'b0, 12'h3FC, 8'h00, r, e);
    check({e, r}, 9'h100);
    apb(1'b1, 12'h265, 8'h12, r, e);
    check({e, r}, 9'h100);
    rchk(USX_IDX_BAUD_DIVISOR, 8'hFF);
  endtask : t_regs

  // reception gated by enable, then each rate range
  task automatic t_rx_rates();
    logic hs [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    logic [7:0] dv [4] = '{8'h00, 8'h03, 8'h01, 8'h00};
    int bc [4] = '{64, 64, 128, 16};
    wreg(USX_IDX_BAUD_DIVISOR, 8'h00);
    wreg(USX_IDX_RX_STATUS_CTRL, 8'h80);
    i_usx_partner.send_frame(9'h081, 8, 64, 1'b1);
    rchk(USX_IDX_PERIPH_FLAGS_1, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wreg(USX_IDX_BAUD_DIVISOR, dv[k]);
      wreg(USX_IDX_TX_STATUS_CTRL, {5'h00, hs[k], 2'h0});
      wreg(USX_IDX_RX_STATUS_CTRL, 8'h90);
      i_usx_partner.send_frame(9'(53 + k * 17), 8, bc[k], 1'b1);
      rchk(USX_IDX_PERIPH_FLAGS_1, 8'h20);
      rchk(USX_IDX_RX_STATUS_CTRL, 8'h90);
      rchk(USX_IDX_RX_DATA, 8'(53 + k * 17));
      rchk(USX_IDX_PERIPH_FLAGS_1, 8'h00);
    end
  endtask : t_rx_rates

  // ninth bit, interrupt, framing, overrun and error clearing
  task automatic t_rx_err();
    wreg(USX_IDX_BAUD_DIVISOR, 8'h00);
    wreg(USX_IDX_TX_STATUS_CTRL, 8'h04);
    wreg(USX_IDX_PERIPH_ENABLES_1, 8'h20);
    wreg(USX_IDX_RX_STATUS_CTRL, 8'hD0);
    sleep_mode <= 1'b1;
    i_usx_partner.send_frame(9'h15A, 9, 16, 1'b1);
    check(int_request, 1'b1);
    check(wake_request, 1'b1);
    sleep_mode <= 1'b0;
    rchk(USX_IDX_RX_STATUS_CTRL, 8'hD1);
    rchk(USX_IDX_RX_DATA, 8'h5A);
    @(posedge clk_sys);
    check(int_request, 1'b0);
    i_usx_partner.send_frame(9'h0C3, 9, 16, 1'b0);
    rchk(USX_IDX_RX_STATUS_CTRL, 8'hD4);
    i_usx_partner.send_frame(9'h0E7, 9, 16, 1'b1);
    rchk(USX_IDX_RX_STATUS_CTRL, 8'hD6);
    rchk(USX_IDX_RX_DATA, 8'hC3);
    wreg(USX_IDX_RX_STATUS_CTRL, 8'hC0);
    rchk(USX_IDX_RX_STATUS_CTRL, 8'hC0);
  endtask : t_rx_err

  // two queued words shifted out by the external clock in sleep
  task automatic t_tx();
    logic [8:0] got;
    wreg(USX_IDX_RX_STATUS_CTRL, 8'h80);
    wreg(USX_IDX_PERIPH_ENABLES_1, 8'h10);
    wreg(USX_IDX_TX_STATUS_CTRL, 8'h71);
    rchk(USX_IDX_PERIPH_FLAGS_1, 8'h10);
    check(pin_oe, 1'b1);
    wreg(USX_IDX_TX_HOLDING, 8'h5A);
    wreg(USX_IDX_TX_HOLDING, 8'h96);
    rchk(USX_IDX_PERIPH_FLAGS_1, 8'h00);
    rchk(USX_IDX_TX_STATUS_CTRL, 8'h71);
    sleep_mode <= 1'b1;
    i_usx_partner.shift_word(9, got);
    check(got, 9'h15A);
    repeat (6) @(posedge clk_sys);
    check(wake_request, 1'b1);
    check(int_request, 1'b1);
    i_usx_partner.shift_word(9, got);
    check(got, 9'h196);
    sleep_mode <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rchk(USX_IDX_TX_STATUS_CTRL, 8'h73);
    wreg(USX_IDX_TX_STATUS_CTRL, 8'h30);
    wreg(USX_IDX_TX_HOLDING, 8'hA5);
    rchk(USX_IDX_PERIPH_FLAGS_1, 8'h10);
    i_usx_partner.shift_word(8, got);
    check(got, 9'h0A5);
  endtask : t_tx

  task automatic conclude();
    $display("comparisons %0d, wrong values %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  // main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_rx_rates();
    t_rx_err();
    t_tx();
    conclude();
  end

  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    conclude();
  end
endmodule : usx_top_tb

`default_nettype wire
